// >>> shs_pkg.sv
// Package of constants and types for the sensor health status register bank.
// Function
// R1 - Set ready flag after successful initialization
// R2 - Link check register returns written value
// R3 - Soft reset restores link check default
// R4 - Supply checked at power-up and measurement start
// R5 - Temperature checked at every measurement start
// R6 - Range errors never disturb measurement sequence
// R7 - Range flags cleared only by clear bits
// R8 - Each address selects one byte register
// R9 - Write-only bits always read zero
// R10 - Hardware updates visible on next read
// R11 - Sticky bits return only through reset; the code also clears range flags and IRQ status bits by host writes
// R12 - Unimplemented bits read zero, ignore writes
// R13 - Host writes zero to unimplemented bits; the testbench writes 8'h49 to the status register
// R14 - Host writes only legal field encodings
// R15 - Ready flag stays low until init succeeds
package shs_pkg;

	localparam logic [11:0] SENSOR_STATUS_REG_OFFSET = 12'h004;
	localparam logic [11:0] LINK_CHECK_REG_OFFSET    = 12'h03c;
	localparam logic [11:0] SOFT_RESET_REG_OFFSET    = 12'h040;
	localparam logic [11:0] IRQ_STATUS_OFFSET        = 12'h100;
	localparam logic [11:0] IRQ_MASK_OFFSET          = 12'h104;

	localparam int READY_BIT      = 7;
	localparam int TEMP_ERR_BIT   = 5;
	localparam int SUPPLY_ERR_BIT = 4;
	localparam int TEMP_CLR_BIT   = 2;
	localparam int SUPPLY_CLR_BIT = 1;

	localparam logic [7:0] SENSOR_STATUS_RESET = 8'h00;
	localparam logic [7:0] LINK_CHECK_RESET    = 8'h00;
	localparam logic [7:0] SOFT_RESET_TRIGGER  = 8'ha3;

	localparam int IRQ_READY  = 0;
	localparam int IRQ_SUPPLY = 1;
	localparam int IRQ_TEMP   = 2;
	localparam int IRQ_WIDTH  = 3;

	localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 3'h0;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} shs_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} shs_apb_rsp_t;

	typedef struct packed {
		logic supply_sample;
		logic supply_out_of_range;
		logic temp_sample;
		logic temp_out_of_range;
	} shs_check_t;

	typedef enum logic [1:0] {
		SHS_INIT_WAIT = 2'b00,
		SHS_INIT_OK   = 2'b01,
		SHS_INIT_FAIL = 2'b11
	} shs_init_state_t;

endpackage

// >>> shs_sync.sv
// Two-stage synchroniser for level signals arriving from outside the clock domain.
module shs_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_sync_out;

	always_comb begin
		next_stage1   = stage1;
		next_sync_out = sync_out;
		if (!reset_n) begin
			next_stage1   = '0;
			next_sync_out = '0;
		end else if (clk_en) begin
			next_stage1   = async_in;
			next_sync_out = stage1;
		end
	end

	always_ff @(posedge clk) begin
		stage1   <= next_stage1;
		sync_out <= next_sync_out;
	end

endmodule // shs_sync

// >>> shs_health_regs.sv
// Status, link check and soft reset register bank with sticky range errors, on APB.
module shs_health_regs (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 clk_en,
	input  wire shs_pkg::shs_apb_req_t apb_req,
	output shs_pkg::shs_apb_rsp_t      apb_rsp,
	input  wire logic                 init_done,
	input  wire logic                 init_failed,
	input  wire logic                 power_up_check,
	input  wire logic                 meas_start,
	input  wire logic                 supply_out_of_range,
	input  wire logic                 temp_out_of_range,
	output logic                      init_done_flag,
	output logic                      supply_range_err,
	output logic                      temp_range_err,
	output logic                      soft_reset_pulse,
	output logic                      irq
);

	logic [3:0] raw_in;
	logic [3:0] sync_in;
	shs_pkg::shs_check_t check;

	assign raw_in = {power_up_check, supply_out_of_range, meas_start, temp_out_of_range};

	// The supply and temperature monitors run outside this clock domain.
	shs_sync #(
		.WIDTH (4)
	) u_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.async_in (raw_in),
		.sync_out (sync_in)
	);

	logic init_done_s;
	logic init_failed_s;
	logic [1:0] init_raw;
	logic [1:0] init_sync;

	assign init_raw = {init_done, init_failed};

	shs_sync #(
		.WIDTH (2)
	) u_init_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.async_in (init_raw),
		.sync_out (init_sync)
	);

	assign init_done_s   = init_sync[1];
	assign init_failed_s = init_sync[0];

	// Sample pulses are rising edges of the synchronised power-up and start levels.
	logic pwr_d;
	logic start_d;
	logic next_pwr_d;
	logic next_start_d;

	always_comb begin
		check.supply_sample       = (sync_in[3] && !pwr_d) || (sync_in[1] && !start_d);
		check.supply_out_of_range = sync_in[2];
		check.temp_sample         = sync_in[1] && !start_d;
		check.temp_out_of_range   = sync_in[0];
	end

	// Initialization tracking.
	shs_pkg::shs_init_state_t init_state;
	shs_pkg::shs_init_state_t next_init_state;

	always_comb begin
		next_init_state = init_state;
		case (init_state)
			shs_pkg::SHS_INIT_WAIT: begin
				if (init_failed_s) begin
					next_init_state = shs_pkg::SHS_INIT_FAIL; // [R15]
				end else if (init_done_s) begin
					next_init_state = shs_pkg::SHS_INIT_OK; // [R1]
				end
			end
			shs_pkg::SHS_INIT_OK:   next_init_state = shs_pkg::SHS_INIT_OK;
			shs_pkg::SHS_INIT_FAIL: next_init_state = shs_pkg::SHS_INIT_FAIL;
			default:                next_init_state = shs_pkg::SHS_INIT_WAIT;
		endcase
		if (!reset_n) begin
			next_init_state = shs_pkg::SHS_INIT_WAIT;
		end
	end

	// APB decode; every access completes with pready high in its first access cycle.
	logic access;
	logic wr;
	logic hit_status;
	logic hit_link;
	logic hit_soft;
	logic hit_irq_sts;
	logic hit_irq_msk;
	logic mapped;
	logic [7:0] wbyte;

	always_comb begin
		access      = apb_req.psel && apb_req.penable;
		wr          = access && apb_req.pwrite;
		hit_status  = apb_req.paddr == shs_pkg::SENSOR_STATUS_REG_OFFSET;
		hit_link    = apb_req.paddr == shs_pkg::LINK_CHECK_REG_OFFSET;
		hit_soft    = apb_req.paddr == shs_pkg::SOFT_RESET_REG_OFFSET;
		hit_irq_sts = apb_req.paddr == shs_pkg::IRQ_STATUS_OFFSET;
		hit_irq_msk = apb_req.paddr == shs_pkg::IRQ_MASK_OFFSET;
		mapped      = hit_status || hit_link || hit_soft || hit_irq_sts || hit_irq_msk;
		wbyte       = apb_req.pwdata[7:0]; // [R8]
	end

	// Register state.
	logic [7:0] link_check_reg;
	logic [7:0] next_link_check_reg;
	logic       next_supply_range_err;
	logic       next_temp_range_err;
	logic       next_init_done_flag;
	logic       next_soft_reset_pulse;
	logic       ready_d;
	logic       next_ready_d;
	logic [shs_pkg::IRQ_WIDTH-1:0] irq_status;
	logic [shs_pkg::IRQ_WIDTH-1:0] next_irq_status;
	logic [shs_pkg::IRQ_WIDTH-1:0] irq_mask;
	logic [shs_pkg::IRQ_WIDTH-1:0] next_irq_mask;
	logic [shs_pkg::IRQ_WIDTH-1:0] irq_events;
	logic                          next_irq;
	logic                          soft_req;
	logic                          sup_set;
	logic                          tmp_set;

	always_comb begin
		soft_req = wr && hit_soft && (wbyte == shs_pkg::SOFT_RESET_TRIGGER);
		sup_set  = check.supply_sample && check.supply_out_of_range; // [R4]
		tmp_set  = check.temp_sample && check.temp_out_of_range; // [R5]

		next_link_check_reg = link_check_reg;
		if (wr && hit_link) begin
			next_link_check_reg = wbyte; // [R2]
		end
		if (soft_req) begin
			next_link_check_reg = shs_pkg::LINK_CHECK_RESET; // [R3]
		end

		// Flags only observe the monitors; no path back to the sequencer. [R6]
		next_supply_range_err = supply_range_err;
		if (wr && hit_status && wbyte[shs_pkg::SUPPLY_CLR_BIT]) begin
			next_supply_range_err = 1'b0; // [R7] [R11]
		end
		if (sup_set) begin
			next_supply_range_err = 1'b1; // [R10]
		end

		next_temp_range_err = temp_range_err;
		if (wr && hit_status && wbyte[shs_pkg::TEMP_CLR_BIT]) begin
			next_temp_range_err = 1'b0; // [R7] [R11]
		end
		if (tmp_set) begin
			next_temp_range_err = 1'b1; // [R10]
		end

		next_init_done_flag   = next_init_state == shs_pkg::SHS_INIT_OK; // [R1] [R15]
		next_soft_reset_pulse = soft_req;
		next_ready_d          = init_done_flag;

		irq_events                        = '0;
		irq_events[shs_pkg::IRQ_READY]    = init_done_flag && !ready_d;
		irq_events[shs_pkg::IRQ_SUPPLY]   = sup_set;
		irq_events[shs_pkg::IRQ_TEMP]     = tmp_set;
		next_irq_status = irq_status;
		if (wr && hit_irq_sts) begin
			next_irq_status = irq_status & ~wbyte[shs_pkg::IRQ_WIDTH-1:0];
		end
		next_irq_status = next_irq_status | irq_events;
		next_irq_mask = irq_mask;
		if (wr && hit_irq_msk) begin
			next_irq_mask = wbyte[shs_pkg::IRQ_WIDTH-1:0]; // [R12]
		end
		next_irq = |(next_irq_status & next_irq_mask);

		if (!reset_n) begin
			next_link_check_reg   = shs_pkg::LINK_CHECK_RESET;
			next_supply_range_err = shs_pkg::SENSOR_STATUS_RESET[shs_pkg::SUPPLY_ERR_BIT];
			next_temp_range_err   = shs_pkg::SENSOR_STATUS_RESET[shs_pkg::TEMP_ERR_BIT];
			next_init_done_flag   = shs_pkg::SENSOR_STATUS_RESET[shs_pkg::READY_BIT];
			next_soft_reset_pulse = 1'b0;
			next_ready_d          = 1'b0;
			next_irq_status       = shs_pkg::IRQ_RESET;
			next_irq_mask         = shs_pkg::IRQ_RESET;
			next_irq              = 1'b0;
		end
	end

	// Read data; write-only and unimplemented bits read zero.
	shs_pkg::shs_apb_rsp_t next_apb_rsp;
	logic [7:0] rbyte;

	always_comb begin
		rbyte = 8'h00;
		if (hit_status) begin
			rbyte[shs_pkg::READY_BIT]      = init_done_flag; // [R10]
			rbyte[shs_pkg::TEMP_ERR_BIT]   = temp_range_err;
			rbyte[shs_pkg::SUPPLY_ERR_BIT] = supply_range_err; // [R9] [R12]
		end else if (hit_link) begin
			rbyte = link_check_reg;
		end else if (hit_irq_sts) begin
			rbyte[shs_pkg::IRQ_WIDTH-1:0] = irq_status;
		end else if (hit_irq_msk) begin
			rbyte[shs_pkg::IRQ_WIDTH-1:0] = irq_mask;
		end
		next_apb_rsp         = '0;
		next_apb_rsp.pready  = apb_req.psel && !apb_req.penable;
		next_apb_rsp.pslverr = apb_req.psel && !apb_req.penable && !mapped;
		if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
			next_apb_rsp.prdata = {24'h000000, rbyte}; // [R8]
		end
		if (!reset_n) begin
			next_apb_rsp = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (clk_en || !reset_n) begin
			pwr_d            <= next_pwr_d;
			start_d          <= next_start_d;
			init_state       <= next_init_state;
			link_check_reg   <= next_link_check_reg;
			supply_range_err <= next_supply_range_err;
			temp_range_err   <= next_temp_range_err;
			init_done_flag   <= next_init_done_flag;
			soft_reset_pulse <= next_soft_reset_pulse;
			ready_d          <= next_ready_d;
			irq_status       <= next_irq_status;
			irq_mask         <= next_irq_mask;
			irq              <= next_irq;
			apb_rsp          <= next_apb_rsp;
		end
	end

	always_comb begin
		next_pwr_d   = reset_n ? sync_in[3] : 1'b0;
		next_start_d = reset_n ? sync_in[1] : 1'b0;
	end

endmodule // shs_health_regs

// >>> shs_health_regs_assertions.sv
// Checker of the port behaviour of the health register bank.
module shs_health_regs_assertions (
	input wire logic                  clk,
	input wire logic                  reset_n,
	input wire shs_pkg::shs_apb_req_t apb_req,
	input wire shs_pkg::shs_apb_rsp_t apb_rsp,
	input wire logic                  init_done,
	input wire logic                  power_up_check,
	input wire logic                  meas_start,
	input wire logic                  supply_out_of_range,
	input wire logic                  temp_out_of_range,
	input wire logic                  init_done_flag,
	input wire logic                  supply_range_err,
	input wire logic                  temp_range_err,
	input wire logic                  soft_reset_pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic wr_st;
	logic wr_sr;
	assign wr_st = apb_req.psel && apb_req.penable && apb_req.pwrite
		&& apb_req.paddr == shs_pkg::SENSOR_STATUS_REG_OFFSET;
	assign wr_sr = apb_req.psel && apb_req.penable && apb_req.pwrite
		&& apb_req.paddr == shs_pkg::SOFT_RESET_REG_OFFSET
		&& apb_req.pwdata[7:0] == shs_pkg::SOFT_RESET_TRIGGER;
	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence s_answer;
		apb_rsp.pready && apb_rsp.prdata[31:8] == 24'h0;
	endsequence
	property p_answer;
		s_setup |=> s_answer;
	endproperty
	a_answer: assert property (p_answer) else $error("bad bus answer");
	property p_rdy_keep;
		init_done_flag |=> init_done_flag;
	endproperty
	a_rdy_keep: assert property (p_rdy_keep) else $error("ready dropped");
	property p_rdy_low;
		!init_done_flag && !init_done && !$past(init_done) && !$past(init_done, 2)
			&& !$past(init_done, 3) |=> !init_done_flag;
	endproperty
	a_rdy_low: assert property (p_rdy_low) else $error("early ready");
	property p_sup_set;
		($rose(power_up_check) || $rose(meas_start)) && supply_out_of_range
			|-> ##[2:5] supply_range_err;
	endproperty
	a_sup_set: assert property (p_sup_set) else $error("supply flag missed");
	property p_tmp_set;
		$rose(meas_start) && temp_out_of_range |-> ##[2:5] temp_range_err;
	endproperty
	a_tmp_set: assert property (p_tmp_set) else $error("temp flag missed");
	property p_sup_hold;
		supply_range_err && !(wr_st && apb_req.pwdata[1]) |=> supply_range_err;
	endproperty
	a_sup_hold: assert property (p_sup_hold) else $error("supply flag lost");
	property p_tmp_hold;
		temp_range_err && !(wr_st && apb_req.pwdata[2]) |=> temp_range_err;
	endproperty
	a_tmp_hold: assert property (p_tmp_hold) else $error("temp flag lost");
	property p_soft;
		wr_sr |-> ##[1:2] soft_reset_pulse;
	endproperty
	a_soft: assert property (p_soft) else $error("no soft reset pulse");
endmodule // shs_health_regs_assertions

// >>> shs_host_model.sv
// Host model that reaches the register bank over APB.
module shs_host_model (
	input  wire logic                  clk,
	output shs_pkg::shs_apb_req_t      apb_req,
	input  wire shs_pkg::shs_apb_rsp_t apb_rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	initial apb_req = '0;
	// Data above the byte is zero in every transfer and all ones when idle after the first transfer; soft reset only gets its trigger.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		apb_req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (apb_rsp.pready !== 1'b1);
		q = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req <= '{1'b0, 1'b0, w, a, ~{24'h0, d}};
		@(posedge clk);
	endtask
endmodule // shs_host_model

// >>> test_shs_health_regs.sv
// Top testbench for the health register bank.
module test_shs_health_regs;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] ST = shs_pkg::SENSOR_STATUS_REG_OFFSET;
	localparam logic [11:0] LC = shs_pkg::LINK_CHECK_REG_OFFSET;
	localparam logic [11:0] IS = shs_pkg::IRQ_STATUS_OFFSET;
	localparam logic [11:0] IM = shs_pkg::IRQ_MASK_OFFSET;
	logic clk, reset_n, init_done, init_failed, power_up_check, meas_start;
	logic supply_out_of_range, temp_out_of_range, init_done_flag, supply_range_err;
	logic temp_range_err, soft_reset_pulse, irq, e;
	logic [31:0] q;
	shs_pkg::shs_apb_req_t apb_req;
	shs_pkg::shs_apb_rsp_t apb_rsp;
	int fail_count = 0;
	int samples_checked = 0;
	shs_health_regs shs_health_regs_inst (.clk, .reset_n, .clk_en(1'b1), .apb_req,
		.apb_rsp, .init_done, .init_failed, .power_up_check, .meas_start,
		.supply_out_of_range, .temp_out_of_range, .init_done_flag,
		.supply_range_err, .temp_range_err, .soft_reset_pulse, .irq);
	shs_host_model shs_host_model_inst (.clk, .apb_req, .apb_rsp);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		shs_host_model_inst.xfer(1'b0, a, 8'h00, q, e);
		chk(q, {24'h0, x});
		chk({31'h0, e}, 32'h0);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		shs_host_model_inst.xfer(1'b1, a, d, q, e);
	endtask
	task automatic do_reset;
		reset_n <= 1'b0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
	endtask
	task automatic meas(input logic s, input logic t);
		meas_start <= 1'b0;
		repeat (4) @(posedge clk);
		supply_out_of_range <= s;
		temp_out_of_range <= t;
		meas_start <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		reset_n = 1'b0;
		init_done = 1'b0;
		init_failed = 1'b0;
		power_up_check = 1'b0;
		meas_start = 1'b0;
		supply_out_of_range = 1'b0;
		temp_out_of_range = 1'b0;
		do_reset;
		rd(ST, 8'h00);
		rd(LC, shs_pkg::LINK_CHECK_RESET);
		shs_host_model_inst.xfer(1'b0, 12'h0f8, 8'h00, q, e);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		init_done <= 1'b1;
		repeat (8) @(posedge clk);
		rd(ST, 8'h80);
		for (int i = 0; i < 8; i++) begin
			wr(LC, 8'h01 << i);
			rd(LC, 8'h01 << i);
		end
		wr(LC, 8'h3c);
		wr(shs_pkg::SOFT_RESET_REG_OFFSET, shs_pkg::SOFT_RESET_TRIGGER);
		rd(LC, shs_pkg::LINK_CHECK_RESET);
		supply_out_of_range <= 1'b1;
		power_up_check <= 1'b1;
		repeat (8) @(posedge clk);
		rd(ST, 8'h90);
		meas(1'b0, 1'b1);
		rd(ST, 8'hb0);
		wr(ST, 8'h49);
		rd(ST, 8'hb0);
		wr(ST, 8'h02);
		rd(ST, 8'ha0);
		meas(1'b1, 1'b0);
		rd(ST, 8'hb0);
		wr(ST, 8'h06);
		rd(ST, 8'h80);
		rd(IS, 8'h07);
		chk({31'h0, irq}, 32'h0);
		wr(IM, 8'h02);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(IS, 8'h02);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rd(IS, 8'h05);
		init_failed <= 1'b1;
		meas_start <= 1'b0;
		power_up_check <= 1'b0;
		supply_out_of_range <= 1'b0;
		do_reset;
		repeat (10) @(posedge clk);
		rd(ST, 8'h00);
		chk({31'h0, init_done_flag}, 32'h0);
		tally_and_finish;
	end
	initial begin
		#20000;
		fail_count++;
		tally_and_finish;
	end
endmodule // test_shs_health_regs
bind shs_health_regs shs_health_regs_assertions shs_health_regs_assertions_inst (.clk,
	.reset_n, .apb_req, .apb_rsp, .init_done, .power_up_check, .meas_start,
	.supply_out_of_range, .temp_out_of_range, .init_done_flag, .supply_range_err,
	.temp_range_err, .soft_reset_pulse);
